/* File: rtl/rmpa_cfg.svh */
// Constants and bit layout of the room mode priority arbiter
// Functional notes
// - Manual presence: press or 1 enters extension from night/protection, not window-caused.
// - Extension ends by itself once its configured length has fully elapsed.
// - Second press or value 0 ends extension early; activity never restarts it.
// - Extension length 0: presence registers active but mode stays night/protection.
// - From standby, press or 1 selects comfort while presence stays active.
// - Presence and its object clear on a change to another mode or release.
// - Detector value 1 forces comfort; only forced object, window and automatic frost outrank it.
// - Detector value 0 returns to earlier or tracked mode; changes wait meanwhile.
// - Any reset clears presence; detector must send a fresh 1 afterwards.
// - Window open enters protection; switch-over objects cannot leave, forced may.
// - Only window closed clears protection, returning to earlier or received mode.
// - Window delay 1 to 255 minutes postpones takeover; 0 acts at once.
// - Window protection acts when heating and cooling; reset clears window status.
// - Automatic frost samples temperature each minute; drop at threshold enters protection.
// - Frost period end returns to earlier mode; drops meanwhile do not restart it.
// - During automatic frost, byte telegrams are tracked, single-bit telegrams discarded.
// - Forced object outranks automatic frost and can interrupt it any time.
// - Automatic frost only when heating below setpoint; never in deadband or cooling.
// - After reset or reprogramming the configured post-reset mode follows initialisation.
// - Restore option reinstates the last mode set by the mode objects only.
// - Mode objects are refreshed after every reset.
// - Switch-over byte selects at once: 01 comfort, 02 standby, 03 night, 04 protection.
// - Forced byte overrides every other source; 00 releases it and clears presence.
`ifndef RMPA_CFG_SVH
`define RMPA_CFG_SVH
`define RMPA_ADDR_CTRL   8'h00
`define RMPA_ADDR_TIME   8'h04
`define RMPA_ADDR_SWO    8'h08
`define RMPA_ADDR_FORCE  8'h0c
`define RMPA_ADDR_BITS   8'h10
`define RMPA_ADDR_PRES   8'h14
`define RMPA_ADDR_WIN    8'h18
`define RMPA_ADDR_TEMP   8'h1c
`define RMPA_ADDR_INIT   8'h20
`define RMPA_ADDR_STAT   8'h24
`define RMPA_CTRL_DET    0
`define RMPA_CTRL_AUTO   1
`define RMPA_CTRL_HEAT   2
`define RMPA_CTRL_COOL   3
`define RMPA_CTRL_DBAND  4
`define RMPA_CTRL_RMODE  7:5
`define RMPA_TIME_EXT    7:0
`define RMPA_TIME_WDLY   15:8
`define RMPA_TIME_FPER   23:16
`define RMPA_TIME_DROP   31:24
`define RMPA_CTRL_RST    32'h0000_0024
`define RMPA_TIME_RST    32'h0a3c_003c
`define RMPA_TEMP_RST    32'h0000_0000
`define RMPA_RMODE_KEEP  3'h4
`define RMPA_OBJ_COMF    8'h01
`define RMPA_OBJ_STBY    8'h02
`define RMPA_OBJ_NIGHT   8'h03
`define RMPA_OBJ_PROT    8'h04
`define RMPA_OBJ_REL     8'h00
`define RMPA_MINUTE_S    64'h0000_0000_0000_003c
`define RMPA_NS_PER_S    64'h0000_0000_3b9a_ca00
`define RMPA_CLK_NS      64'h0000_0000_0000_000a
`define RMPA_INIT_CYC    8'h10
`endif

/* File: rtl/rmpa_pkg.sv */
// Types of the room mode priority arbiter
package rmpa_pkg;
  typedef enum logic [2:0] {
    MODE_COMFORT,
    MODE_STANDBY,
    MODE_NIGHT,
    MODE_PROTECT,
    MODE_EXTEND
  } rmpa_mode_type;
  typedef enum logic {
    ST_INIT,
    ST_RUN
  } rmpa_state_type;
endpackage : rmpa_pkg

/* File: rtl/rmpa_arbiter.sv */
// Operating mode arbitration with Wishbone register access
`timescale 1ns/1ps
`include "rmpa_cfg.svh"
module rmpa_arbiter #(
  parameter longint unsigned MINUTE_CYCLES =
    (`RMPA_MINUTE_S * `RMPA_NS_PER_S) / `RMPA_CLK_NS
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Mode outputs
  output logic      [2:0]  active_mode,
  output logic      [7:0]  mode_obj,
  output logic             mode_update,
  output logic             presence_obj
);

  if (MINUTE_CYCLES < 64'h1 || MINUTE_CYCLES > 64'hf_ffff_ffff) begin : g_chk
    $error("MINUTE_CYCLES out of range");
  end

  localparam logic [35:0] MIN_LAST = 36'(MINUTE_CYCLES - 64'h1);

  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic obj_ok(input logic [7:0] v);
    return v >= `RMPA_OBJ_COMF && v <= `RMPA_OBJ_PROT;
  endfunction : obj_ok

  function automatic rmpa_pkg::rmpa_mode_type obj_mode(input logic [7:0] v);
    case (v)
      `RMPA_OBJ_COMF:  return rmpa_pkg::MODE_COMFORT;
      `RMPA_OBJ_NIGHT: return rmpa_pkg::MODE_NIGHT;
      `RMPA_OBJ_PROT:  return rmpa_pkg::MODE_PROTECT;
      default:         return rmpa_pkg::MODE_STANDBY;
    endcase
  endfunction : obj_mode

  function automatic logic [7:0] mode_byte(input rmpa_pkg::rmpa_mode_type m);
    case (m)
      rmpa_pkg::MODE_COMFORT: return `RMPA_OBJ_COMF;
      rmpa_pkg::MODE_EXTEND:  return `RMPA_OBJ_COMF;
      rmpa_pkg::MODE_NIGHT:   return `RMPA_OBJ_NIGHT;
      rmpa_pkg::MODE_PROTECT: return `RMPA_OBJ_PROT;
      default:                return `RMPA_OBJ_STBY;
    endcase
  endfunction : mode_byte

  // Registers and state
  logic [31:0]            ctrl;
  logic [31:0]            timing;
  logic [31:0]            temp;
  rmpa_pkg::rmpa_state_type state;
  logic [7:0]             init_cnt;
  logic [35:0]            pre_cnt;
  logic                   tick;
  rmpa_pkg::rmpa_mode_type base;
  rmpa_pkg::rmpa_mode_type nv_mode;
  logic                   forced_on;
  rmpa_pkg::rmpa_mode_type forced_mode;
  logic                   pres;
  logic                   ext_run;
  logic [7:0]             ext_cnt;
  logic                   win_raw;
  logic                   win_eff;
  logic [7:0]             win_cnt;
  logic                   frost_act;
  logic [7:0]             frost_cnt;
  logic [15:0]            prev_temp;
  logic                   samp_ok;
  logic                   prot_q;
  logic                   init_q;
  rmpa_pkg::rmpa_mode_type next_mode;

  // Bus decode; writes land on the edge that sees ack high
  logic        req;
  logic        wr_en;
  logic        run;
  logic        init_done;
  logic        soft_init;
  logic        tg_swo;
  logic        tg_frc;
  logic        tg_bits;
  logic        tg_pres;
  logic        tg_win;
  logic        det;
  logic        press;
  logic        pval;
  logic        swo_ok;
  logic        bits_ok;
  rmpa_pkg::rmpa_mode_type bits_mode;
  logic [7:0]  ext_len;
  logic [7:0]  win_dly;
  logic        frost_start;
  logic        clr_pres;
  logic        act_pres;
  logic        end_pres;
  logic signed [16:0] drop;

  assign req       = cyc_i & stb_i;
  assign wr_en     = req & ack_o & we_i;
  assign run       = state == rmpa_pkg::ST_RUN;
  assign init_done = state == rmpa_pkg::ST_INIT && init_cnt == 8'h00;
  assign soft_init = wr_en & sel_i[0] & adr_i == `RMPA_ADDR_INIT & dat_i[0];
  assign tg_swo    = run & wr_en & sel_i[0] & adr_i == `RMPA_ADDR_SWO;
  assign tg_frc    = run & wr_en & sel_i[0] & adr_i == `RMPA_ADDR_FORCE;
  assign tg_bits   = run & wr_en & sel_i[0] & adr_i == `RMPA_ADDR_BITS;
  assign tg_pres   = run & wr_en & sel_i[0] & adr_i == `RMPA_ADDR_PRES;
  assign tg_win    = run & wr_en & sel_i[0] & adr_i == `RMPA_ADDR_WIN;
  assign det       = ctrl[`RMPA_CTRL_DET];
  assign press     = tg_pres & dat_i[1];
  assign pval      = dat_i[0];
  assign swo_ok    = tg_swo & obj_ok(dat_i[7:0]);
  assign ext_len   = timing[`RMPA_TIME_EXT];
  assign win_dly   = timing[`RMPA_TIME_WDLY];
  // Protection bit wins, then comfort, standby, night
  assign bits_ok   = tg_bits & (|dat_i[3:0]);
  assign bits_mode = dat_i[3] ? rmpa_pkg::MODE_PROTECT :
                     dat_i[0] ? rmpa_pkg::MODE_COMFORT :
                     dat_i[1] ? rmpa_pkg::MODE_STANDBY :
                     rmpa_pkg::MODE_NIGHT;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req & ~ack_o;
      if (req & ~ack_o) begin
        case (adr_i)
          `RMPA_ADDR_CTRL: dat_o <= ctrl;
          `RMPA_ADDR_TIME: dat_o <= timing;
          `RMPA_ADDR_TEMP: dat_o <= temp;
          `RMPA_ADDR_STAT: dat_o <= {13'h0000, nv_mode, mode_obj, run,
                                     forced_on, frost_act, win_eff,
                                     presence_obj, active_mode};
          default:         dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl   <= `RMPA_CTRL_RST;
      timing <= `RMPA_TIME_RST;
      temp   <= `RMPA_TEMP_RST;
    end else if (wr_en) begin
      if (adr_i == `RMPA_ADDR_CTRL) ctrl <= merge(ctrl, dat_i, sel_i);
      if (adr_i == `RMPA_ADDR_TIME) timing <= merge(timing, dat_i, sel_i);
      if (adr_i == `RMPA_ADDR_TEMP) temp <= merge(temp, dat_i, sel_i);
    end
  end

  // Initialisation phase; soft init keeps the stored mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state    <= rmpa_pkg::ST_INIT;
      init_cnt <= `RMPA_INIT_CYC;
    end else if (soft_init) begin
      state    <= rmpa_pkg::ST_INIT;
      init_cnt <= `RMPA_INIT_CYC;
    end else begin
      case (state)
        rmpa_pkg::ST_INIT: begin
          if (init_cnt == 8'h00) state <= rmpa_pkg::ST_RUN;
          else init_cnt <= init_cnt - 8'h01;
        end
        rmpa_pkg::ST_RUN: state <= rmpa_pkg::ST_RUN;
        default: state <= rmpa_pkg::ST_INIT;
      endcase
    end
  end

  // Minute prescaler shared by all timers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt <= 36'h0_0000_0000;
      tick    <= 1'b0;
    end else begin
      tick <= pre_cnt == MIN_LAST;
      if (pre_cnt == MIN_LAST) pre_cnt <= 36'h0_0000_0000;
      else pre_cnt <= pre_cnt + 36'h0_0000_0001;
    end
  end

  // Mode objects and forced object
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      base        <= rmpa_pkg::MODE_STANDBY;
      nv_mode     <= rmpa_pkg::MODE_STANDBY;
      forced_on   <= 1'b0;
      forced_mode <= rmpa_pkg::MODE_STANDBY;
    end else if (soft_init) begin
      forced_on <= 1'b0;
    end else if (init_done) begin
      if (ctrl[`RMPA_CTRL_RMODE] == `RMPA_RMODE_KEEP) base <= nv_mode;
      else base <= obj_mode({5'h00, ctrl[`RMPA_CTRL_RMODE]} + 8'h01);
    end else begin
      if (swo_ok) begin
        base    <= obj_mode(dat_i[7:0]);
        nv_mode <= obj_mode(dat_i[7:0]);
      end
      // Single-bit objects are dropped while frost protection runs
      if (bits_ok && !frost_act) begin
        base    <= bits_mode;
        nv_mode <= bits_mode;
      end
      if (tg_frc) begin
        if (dat_i[7:0] == `RMPA_OBJ_REL) begin
          forced_on <= 1'b0;
        end else if (obj_ok(dat_i[7:0])) begin
          forced_on   <= 1'b1;
          forced_mode <= obj_mode(dat_i[7:0]);
        end
      end
    end
  end

  // Window status with optional delay
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      win_raw <= 1'b0;
      win_eff <= 1'b0;
      win_cnt <= 8'h00;
    end else if (soft_init) begin
      win_raw <= 1'b0;
      win_eff <= 1'b0;
      win_cnt <= 8'h00;
    end else if (tg_win && !pval) begin
      win_raw <= 1'b0;
      win_eff <= 1'b0;
    end else if (tg_win && !win_raw) begin
      win_raw <= 1'b1;
      win_cnt <= win_dly;
      if (win_dly == 8'h00) win_eff <= 1'b1;
    end else if (tick && win_raw && !win_eff) begin
      // Extra tick so a partial first minute never shortens the delay
      if (win_cnt == 8'h00) win_eff <= 1'b1;
      else win_cnt <= win_cnt - 8'h01;
    end
  end

  // Automatic frost protection
  assign drop = 17'(signed'(prev_temp)) - 17'(signed'(temp[15:0]));
  assign frost_start = run & tick & samp_ok & ~frost_act & ~forced_on
                     & ctrl[`RMPA_CTRL_AUTO]
                     & ctrl[`RMPA_CTRL_HEAT] & ~ctrl[`RMPA_CTRL_COOL]
                     & ~ctrl[`RMPA_CTRL_DBAND]
                     & (signed'(temp[15:0]) < signed'(temp[31:16]))
                     & (timing[`RMPA_TIME_DROP] != 8'h00)
                     & (drop >= signed'({9'h000, timing[`RMPA_TIME_DROP]}));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_temp <= 16'h0000;
      samp_ok   <= 1'b0;
    end else if (soft_init) begin
      samp_ok <= 1'b0;
    end else if (tick) begin
      prev_temp <= temp[15:0];
      samp_ok   <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frost_act <= 1'b0;
      frost_cnt <= 8'h00;
    end else if (soft_init || forced_on) begin
      frost_act <= 1'b0;
    end else if (frost_start) begin
      frost_act <= 1'b1;
      frost_cnt <= timing[`RMPA_TIME_FPER];
    end else if (tick && frost_act) begin
      // Drops seen here never reload the period
      if (frost_cnt == 8'h00) frost_act <= 1'b0;
      else frost_cnt <= frost_cnt - 8'h01;
    end
  end

  // Presence button and detector
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) prot_q <= 1'b0;
    else prot_q <= win_eff | frost_act;
  end

  assign clr_pres = (tg_frc & dat_i[7:0] == `RMPA_OBJ_REL & forced_on)
                  | (~det & (swo_ok | bits_ok | (tg_frc & obj_ok(dat_i[7:0]))
                             | ((win_eff | frost_act) & ~prot_q)));
  assign act_pres = ~det & ~pres & ~forced_on & ~win_eff
                  & (press | (tg_pres & pval));
  assign end_pres = ~det & pres & (press | (tg_pres & ~pval));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pres    <= 1'b0;
      ext_run <= 1'b0;
      ext_cnt <= 8'h00;
    end else if (soft_init || state == rmpa_pkg::ST_INIT) begin
      pres    <= 1'b0;
      ext_run <= 1'b0;
    end else if (clr_pres) begin
      pres    <= 1'b0;
      ext_run <= 1'b0;
    end else if (det) begin
      ext_run <= 1'b0;
      if (tg_pres) pres <= pval;
    end else if (end_pres) begin
      pres    <= 1'b0;
      ext_run <= 1'b0;
    end else if (act_pres) begin
      pres <= 1'b1;
      if ((active_mode == rmpa_pkg::MODE_NIGHT ||
           active_mode == rmpa_pkg::MODE_PROTECT) && ext_len != 8'h00) begin
        ext_run <= 1'b1;
        ext_cnt <= ext_len;
      end
    end else if (tick && ext_run) begin
      if (ext_cnt == 8'h00) begin
        pres    <= 1'b0;
        ext_run <= 1'b0;
      end else begin
        ext_cnt <= ext_cnt - 8'h01;
      end
    end
  end

  // Priority: forced, window, frost, presence, mode objects
  always_comb begin
    if (forced_on) next_mode = forced_mode;
    else if (win_eff) next_mode = rmpa_pkg::MODE_PROTECT;
    else if (frost_act) next_mode = rmpa_pkg::MODE_PROTECT;
    else if (det && pres) next_mode = rmpa_pkg::MODE_COMFORT;
    else if (pres && ext_run) next_mode = rmpa_pkg::MODE_EXTEND;
    else if (pres && base == rmpa_pkg::MODE_STANDBY)
      next_mode = rmpa_pkg::MODE_COMFORT;
    else next_mode = base;
  end

  // Outputs; object refresh after each initialisation
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      active_mode  <= rmpa_pkg::MODE_STANDBY;
      mode_obj     <= `RMPA_OBJ_STBY;
      mode_update  <= 1'b0;
      presence_obj <= 1'b0;
      init_q       <= 1'b0;
    end else begin
      presence_obj <= pres;
      init_q       <= init_done;
      mode_update  <= 1'b0;
      if (run) begin
        active_mode <= next_mode;
        mode_obj    <= mode_byte(next_mode);
        // Refresh rides with the first run mode so the pulse stays single
        mode_update <= next_mode != active_mode || init_q;
      end
    end
  end

endmodule : rmpa_arbiter

/* File: tb/rmpa_arbiter_asserts.sv */
// Port checker of the room mode priority arbiter
`timescale 1ns/1ps
`include "rmpa_cfg.svh"
module rmpa_arbiter_asserts (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // Wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Mode outputs
  input wire logic [2:0]  active_mode,
  input wire logic [7:0]  mode_obj,
  input wire logic        mode_update,
  input wire logic        presence_obj
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic run_seen;
  logic det_mode;
  wire  wr_ack = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  // Telegrams only count once init has announced its mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) run_seen <= 1'b0;
    else if (mode_update) run_seen <= 1'b1;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) det_mode <= 1'b0;
    else if (wr_ack && adr_i == `RMPA_ADDR_CTRL) det_mode <= dat_i[0];
  end
  sequence s_force_night;
    wr_ack && run_seen && adr_i == `RMPA_ADDR_FORCE && dat_i[7:0] == 8'h03;
  endsequence
  sequence s_leave_comfort;
    !det_mode && $changed(active_mode) && active_mode inside
      {rmpa_pkg::MODE_STANDBY, rmpa_pkg::MODE_NIGHT, rmpa_pkg::MODE_PROTECT};
  endsequence
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than a cycle");
  a_obj_matches: assert property (mode_obj == ((active_mode == 3'h4) ?
    8'h01 : {5'h00, active_mode} + 8'h01)) else $error("object byte wrong");
  a_update_on_change: assert property ($changed(active_mode) |-> mode_update)
    else $error("mode change without update");
  a_update_single: assert property (mode_update |=> !mode_update)
    else $error("update longer than a cycle");
  a_reset_state: assert property ($rose(resetn) |-> !presence_obj &&
    active_mode == rmpa_pkg::MODE_STANDBY && !ack_o) else $error("reset state");
  a_presence_clear: assert property (s_leave_comfort |-> ##[1:2] !presence_obj)
    else $error("presence kept");
  a_force_wins: assert property (s_force_night |-> ##2
    active_mode == rmpa_pkg::MODE_NIGHT) else $error("forced mode ignored");
endmodule : rmpa_arbiter_asserts
bind rmpa_arbiter rmpa_arbiter_asserts u_chk (.ref_clk(ref_clk),
  .resetn(resetn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .active_mode(active_mode), .mode_obj(mode_obj), .mode_update(mode_update),
  .presence_obj(presence_obj));

/* File: tb/rmpa_bus_node.sv */
// Bus node model that sends telegrams over classic Wishbone
`timescale 1ns/1ps
module rmpa_bus_node (
  // Clock
  input  wire logic        ref_clk,
  // Wishbone master
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'hff;
    sel_o = 4'h0;
    dat_o = 32'hffff_ffff;
  end
  // Released lines show the inverse so a stale value never looks valid
  task automatic xfer(input logic wr, input logic [7:0] adr,
                      input logic [31:0] wdat, output logic [31:0] rdat,
                      output logic ok);
    int n;
    @(posedge ref_clk);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= wr;
    adr_o <= adr;
    sel_o <= 4'hf;
    dat_o <= wdat;
    n = 0;
    ok = 1'b0;
    while (n < 40 && !ok) begin
      @(posedge ref_clk);
      n++;
      ok = (ack_i === 1'b1);
    end
    rdat = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~adr;
    dat_o <= ~wdat;
  endtask : xfer
endmodule : rmpa_bus_node

/* File: tb/room_mode_priority_arbiter_test.sv */
// Self-checking bench of the room mode priority arbiter
`timescale 1ns/1ps
`include "rmpa_cfg.svh"
module room_mode_priority_arbiter_test;
  localparam int MIN = 20;
  localparam logic [2:0] CF = rmpa_pkg::MODE_COMFORT;
  localparam logic [2:0] SB = rmpa_pkg::MODE_STANDBY;
  localparam logic [2:0] NT = rmpa_pkg::MODE_NIGHT;
  localparam logic [2:0] PR = rmpa_pkg::MODE_PROTECT;
  localparam logic [2:0] EX = rmpa_pkg::MODE_EXTEND;
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [2:0]  mode;
  } rmpa_row_type;
  logic         ref_clk;
  logic         resetn;
  logic         cyc;
  logic         stb;
  logic         we;
  logic [7:0]   adr;
  logic [3:0]   sel;
  logic [31:0]  wdat;
  logic [31:0]  rdat;
  logic         ack;
  logic [2:0]   mode;
  logic [7:0]   obj;
  logic         upd;
  logic         pres;
  int           fails;
  int           checks;
  rmpa_row_type rows [11];
  rmpa_arbiter #(.MINUTE_CYCLES(MIN)) dut (.ref_clk(ref_clk),
    .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .active_mode(mode), .mode_obj(obj), .mode_update(upd),
    .presence_obj(pres));
  rmpa_bus_node node (.ref_clk(ref_clk), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat),
    .ack_i(ack));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic bus(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        ok;
    node.xfer(1'b1, a, d, q, ok);
    if (!ok) begin
      $display("ERROR %0t no ack", $time);
      fails++;
      print_verdict();
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic        ok;
    node.xfer(1'b0, a, 32'h0000_0000, q, ok);
    checks++;
    if (!ok || q !== e) begin
      $display("ERROR %0t read %h", $time, q);
      fails++;
    end
  endtask : rd
  // Zero limit compares at once; otherwise waits up to lim edges
  task automatic check(input logic [2:0] m, input logic p, input int lim);
    int n;
    n = 0;
    while (n < lim && !(mode === m && pres === p)) begin
      @(posedge ref_clk);
      n++;
    end
    checks++;
    if (!(mode === m && pres === p)) begin
      $display("ERROR %0t mode %0d pres %0b", $time, mode, pres);
      fails++;
      if (lim > 0) print_verdict();
    end
  endtask : check
  task automatic wait_run;
    int n;
    n = 0;
    while (n < 40 && upd !== 1'b1) begin
      @(posedge ref_clk);
      n++;
    end
    if (upd !== 1'b1) begin
      $display("ERROR %0t no init refresh", $time);
      fails++;
      print_verdict();
    end
    repeat (2) @(posedge ref_clk);
  endtask : wait_run
  initial begin
    resetn = 1'b0;
    fails = 0;
    checks = 0;
    rows = '{'{`RMPA_ADDR_SWO, 32'h1, CF}, '{`RMPA_ADDR_SWO, 32'h2, SB},
      '{`RMPA_ADDR_SWO, 32'h3, NT}, '{`RMPA_ADDR_SWO, 32'h4, PR},
      '{`RMPA_ADDR_BITS, 32'h1, CF}, '{`RMPA_ADDR_BITS, 32'h2, SB},
      '{`RMPA_ADDR_BITS, 32'h4, NT}, '{`RMPA_ADDR_BITS, 32'h9, PR},
      '{`RMPA_ADDR_FORCE, 32'h3, NT}, '{`RMPA_ADDR_SWO, 32'h1, NT},
      '{`RMPA_ADDR_FORCE, 32'h0, CF}};
    repeat (5) @(posedge ref_clk);
    check(SB, 1'b0, 0);
    resetn <= 1'b1;
    wait_run();
    rd(`RMPA_ADDR_STAT, 32'h0001_0281);
    foreach (rows[i]) begin
      bus(rows[i].adr, rows[i].dat);
      check(rows[i].mode, 1'b0, 4);
    end
    bus(`RMPA_ADDR_TIME, 32'h0a00_0002);
    bus(`RMPA_ADDR_SWO, 32'h3);
    bus(`RMPA_ADDR_PRES, 32'h2);
    check(EX, 1'b1, 4);
    repeat (2 * MIN - 2) @(posedge ref_clk);
    check(EX, 1'b1, 0);
    bus(`RMPA_ADDR_PRES, 32'h1);
    check(NT, 1'b0, MIN + 5);
    bus(`RMPA_ADDR_PRES, 32'h2);
    check(EX, 1'b1, 4);
    bus(`RMPA_ADDR_PRES, 32'h0);
    check(NT, 1'b0, 4);
    bus(`RMPA_ADDR_TIME, 32'h0a00_0000);
    bus(`RMPA_ADDR_PRES, 32'h2);
    repeat (4) @(posedge ref_clk);
    check(NT, 1'b1, 0);
    bus(`RMPA_ADDR_SWO, 32'h2);
    bus(`RMPA_ADDR_PRES, 32'h2);
    check(CF, 1'b1, 4);
    rd(`RMPA_ADDR_STAT, 32'h0001_0188);
    bus(`RMPA_ADDR_WIN, 32'h1);
    check(PR, 1'b0, 4);
    bus(`RMPA_ADDR_PRES, 32'h2);
    bus(`RMPA_ADDR_SWO, 32'h3);
    repeat (4) @(posedge ref_clk);
    check(PR, 1'b0, 0);
    bus(`RMPA_ADDR_FORCE, 32'h3);
    check(NT, 1'b0, 4);
    bus(`RMPA_ADDR_FORCE, 32'h0);
    check(PR, 1'b0, 4);
    bus(`RMPA_ADDR_WIN, 32'h0);
    check(NT, 1'b0, 4);
    bus(`RMPA_ADDR_TIME, 32'h0a00_0100);
    bus(`RMPA_ADDR_WIN, 32'h1);
    repeat (5) @(posedge ref_clk);
    check(NT, 1'b0, 0);
    check(PR, 1'b0, 2 * MIN + 5);
    bus(`RMPA_ADDR_WIN, 32'h0);
    check(NT, 1'b0, 4);
    bus(`RMPA_ADDR_CTRL, 32'h0000_0026);
    bus(`RMPA_ADDR_TIME, 32'h0501_0000);
    bus(`RMPA_ADDR_TEMP, 32'h0100_00f0);
    repeat (2 * MIN) @(posedge ref_clk);
    bus(`RMPA_ADDR_TEMP, 32'h0100_00e0);
    check(PR, 1'b0, 2 * MIN + 5);
    check(NT, 1'b0, 2 * MIN + 5);
    bus(`RMPA_ADDR_CTRL, 32'h0000_0080);
    bus(`RMPA_ADDR_SWO, 32'h1);
    bus(`RMPA_ADDR_WIN, 32'h1);
    check(PR, 1'b0, 4);
    bus(`RMPA_ADDR_INIT, 32'h1);
    check(CF, 1'b0, 60);
    resetn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check(SB, 1'b0, 0);
    resetn <= 1'b1;
    wait_run();
    bus(`RMPA_ADDR_CTRL, 32'h0000_0021);
    bus(`RMPA_ADDR_PRES, 32'h1);
    check(CF, 1'b1, 4);
    bus(`RMPA_ADDR_SWO, 32'h3);
    repeat (4) @(posedge ref_clk);
    check(CF, 1'b1, 0);
    bus(`RMPA_ADDR_PRES, 32'h0);
    check(NT, 1'b0, 4);
    print_verdict();
  end
endmodule : room_mode_priority_arbiter_test
